// *** logic/rtc_top.sv ***
`timescale 1ns/1ps
`include "rtc_cfg.svh"
module rtc_top import rtc_pkg::*; #(
  parameter int          NUM_RELAYS   = 2,
  parameter logic [7:0]  FITTED_MASK  = 8'hFF,
  parameter int unsigned TENTH_CYCLES = `RTC_TENTH_NS / `RTC_CLK_NS
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire rtc_avs_req_s          avs_req,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic [31:0]           flow_rate,
  input  wire logic [31:0]           total_count,
  input  wire logic                  volume_pulse,
  input  wire logic                  critical,
  input  wire logic                  key_start_pause,
  input  wire logic                  key_clear,
  input  wire logic                  menu_clear,
  input  wire logic                  prog_input_clear,
  input  wire logic                  batch_count_clear,
  output logic [NUM_RELAYS-1:0]      relay_out,
  output logic [NUM_RELAYS-1:0]      led_out,
  output logic                       batch_overflow_flag
);

  // Time base: one pulse per 0.1 s and one per second
  logic [31:0] pre_cnt, next_pre_cnt;
  logic [7:0]  sec_cnt, next_sec_cnt;
  logic        tick_tenth, next_tick_tenth;
  logic        tick_sec, next_tick_sec;

  always_comb begin
    next_pre_cnt    = pre_cnt + 32'h1;
    next_sec_cnt    = sec_cnt;
    next_tick_tenth = 1'b0;
    next_tick_sec   = 1'b0;
    if (pre_cnt >= 32'(TENTH_CYCLES - 1)) begin
      next_pre_cnt    = 32'h0;
      next_tick_tenth = 1'b1;
      next_sec_cnt    = sec_cnt + 8'h1;
      if (sec_cnt >= `RTC_SEC_TENTHS - 8'h1) begin
        next_sec_cnt  = 8'h0;
        next_tick_sec = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pre_cnt    <= 32'h0;
      sec_cnt    <= 8'h0;
      tick_tenth <= 1'b0;
      tick_sec   <= 1'b0;
    end else begin
      pre_cnt    <= next_pre_cnt;
      sec_cnt    <= next_sec_cnt;
      tick_tenth <= next_tick_tenth;
      tick_sec   <= next_tick_sec;
    end
  end

  // Register file and bus slave
  rtc_relay_cfg_s cfg [NUM_RELAYS];
  rtc_relay_cfg_s next_cfg [NUM_RELAYS];
  rtc_auto_cfg_s  auto_cfg, next_auto_cfg;
  logic [31:0]    next_readdata;
  logic           next_waitrequest;
  logic           host_clear, host_start, host_stop, host_cnt_clr;
  logic           take;
  logic [31:0]    batch_cnt, batch_total;
  rtc_bstate_e    bstate;
  logic [31:0]    be_mask;

  assign take    = (avs_req.read | avs_req.write) & avs_waitrequest;
  assign be_mask = {{8{avs_req.byteenable[3]}}, {8{avs_req.byteenable[2]}},
                    {8{avs_req.byteenable[1]}}, {8{avs_req.byteenable[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  always_comb begin
    logic [31:0] w;
    logic [31:0] rel;
    int          idx;
    w                = 32'h0;
    rel              = 32'h0;
    idx              = 0;
    next_cfg         = cfg;
    next_auto_cfg    = auto_cfg;
    next_readdata    = avs_readdata;
    next_waitrequest = 1'b1;
    host_clear       = 1'b0;
    host_start       = 1'b0;
    host_stop        = 1'b0;
    host_cnt_clr     = 1'b0;
    if (take) begin
      next_waitrequest = 1'b0;
      next_readdata    = 32'h0;
      case (avs_req.address)
        `RTC_OFF_RESULT: begin
          next_readdata = batch_cnt;
          if (avs_req.write) begin
            host_clear = (avs_req.writedata == `RTC_CMD_CLEAR);
            host_start = (avs_req.writedata == `RTC_CMD_START);
            host_stop  = (avs_req.writedata == `RTC_CMD_STOP);
          end
        end
        `RTC_OFF_STATUS: begin
          next_readdata = {16'h0, 8'(relay_out), 3'h0, batch_overflow_flag, bstate};
        end
        `RTC_OFF_COUNT: begin
          next_readdata = batch_total;
          host_cnt_clr  = avs_req.write & (avs_req.writedata == `RTC_COUNT_CLR_KEY);
        end
        `RTC_OFF_AUTO: begin
          next_readdata = {auto_cfg.delay, 14'h0, auto_cfg.tbase_sec, auto_cfg.enable};
          if (avs_req.write) begin
            w = merge(next_readdata, avs_req.writedata, be_mask);
            next_auto_cfg = '{enable: w[0], tbase_sec: w[1], delay: w[31:16]};
          end
        end
        default: begin
          rel = 32'(avs_req.address) - 32'(`RTC_OFF_RELAY0);
          idx = int'(rel / 32'(`RTC_RELAY_STRIDE));
          if (avs_req.address >= `RTC_OFF_RELAY0 && idx < NUM_RELAYS
              && rel[1:0] == 2'h0) begin
            case (rel[4:2])
              `RTC_ROFF_CTRL:
                next_readdata = {24'h0, cfg[idx].tbase_sec, cfg[idx].fault,
                                 cfg[idx].mode, cfg[idx].src};
              `RTC_ROFF_SP1:   next_readdata = cfg[idx].sp1;
              `RTC_ROFF_SP2:   next_readdata = cfg[idx].sp2;
              `RTC_ROFF_HYSTERESIS_WIDTH:  next_readdata = cfg[idx].hysteresis_width;
              `RTC_ROFF_DELAY: next_readdata = {cfg[idx].toff, cfg[idx].ton};
              default:         next_readdata = 32'h0;
            endcase
            if (avs_req.write) begin
              w = merge(next_readdata, avs_req.writedata, be_mask);
              case (rel[4:2])
                `RTC_ROFF_CTRL: begin
                  next_cfg[idx].src       = rtc_src_e'(w[1:0]);
                  next_cfg[idx].mode      = rtc_mode_e'(w[4:2]);
                  next_cfg[idx].fault     = rtc_fault_e'(w[6:5]);
                  next_cfg[idx].tbase_sec = w[7];
                end
                `RTC_ROFF_SP1:   next_cfg[idx].sp1 = w;
                `RTC_ROFF_SP2:   next_cfg[idx].sp2 = w;
                `RTC_ROFF_HYSTERESIS_WIDTH:  next_cfg[idx].hysteresis_width = w;
                `RTC_ROFF_DELAY: begin
                  next_cfg[idx].ton  = w[15:0];
                  next_cfg[idx].toff = w[31:16];
                end
                default: begin
                end
              endcase
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_RELAYS; i++) begin
        cfg[i] <= '0;
      end
      auto_cfg        <= '0;
      avs_readdata    <= 32'h0;
      avs_waitrequest <= 1'b1;
    end else begin
      cfg             <= next_cfg;
      auto_cfg        <= next_auto_cfg;
      avs_readdata    <= next_readdata;
      avs_waitrequest <= next_waitrequest;
    end
  end

  // Batcher: primary relay 0 owns the batch setpoint
  rtc_bstate_e bstate_n;
  logic [31:0] next_batch_cnt, next_batch_total;
  logic        next_overflow;
  logic [15:0] auto_cnt, next_auto_cnt;
  logic        start_ev, clear_ev, auto_tick;

  assign start_ev  = key_start_pause | host_start;
  assign clear_ev  = key_clear | menu_clear | host_clear | prog_input_clear;
  assign auto_tick = auto_cfg.tbase_sec ? tick_sec : tick_tenth;

  always_comb begin
    bstate_n         = bstate;
    next_batch_cnt   = batch_cnt;
    next_batch_total = batch_total;
    next_overflow    = batch_overflow_flag;
    next_auto_cnt    = 16'h0;
    if (volume_pulse) begin
      if (batch_cnt == 32'hFFFFFFFF) begin
        next_overflow = 1'b1;
      end else begin
        next_batch_cnt = batch_cnt + 32'h1;
      end
    end
    case (bstate)
      RTC_B_IDLE: begin
        if (start_ev) begin
          bstate_n         = RTC_B_RUN;
          next_batch_total = batch_total + 32'h1;
        end
      end
      RTC_B_RUN: begin
        if (key_start_pause | host_stop) begin
          bstate_n = RTC_B_PAUSE;
        end else if (next_batch_cnt >= cfg[0].sp1) begin
          bstate_n = RTC_B_DONE;
        end
      end
      RTC_B_PAUSE: begin
        if (start_ev) begin
          bstate_n = RTC_B_RUN;
        end
      end
      RTC_B_DONE: begin
        if (auto_cfg.enable) begin
          next_auto_cnt = auto_cnt + {15'h0, auto_tick};
          if (auto_cnt >= auto_cfg.delay) begin
            next_auto_cnt    = 16'h0;
            bstate_n         = RTC_B_RUN;
            next_batch_cnt   = 32'h0;
            next_overflow    = 1'b0;
            next_batch_total = batch_total + 32'h1;
          end
        end
      end
      default: bstate_n = RTC_B_IDLE;
    endcase
    if (clear_ev) begin
      next_batch_cnt = 32'h0;
      next_overflow  = 1'b0;
      next_auto_cnt  = 16'h0;
      bstate_n       = RTC_B_IDLE;
      if (prog_input_clear) begin
        bstate_n         = RTC_B_RUN;
        next_batch_total = batch_total + 32'h1;
      end
    end
    if (batch_count_clear | host_cnt_clr) begin
      next_batch_total = 32'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bstate              <= RTC_B_IDLE;
      batch_cnt           <= 32'h0;
      batch_total         <= 32'h0;
      batch_overflow_flag <= 1'b0;
      auto_cnt            <= 16'h0;
    end else begin
      bstate              <= bstate_n;
      batch_cnt           <= next_batch_cnt;
      batch_total         <= next_batch_total;
      batch_overflow_flag <= next_overflow;
      auto_cnt            <= next_auto_cnt;
    end
  end

  // Threshold relays, one per generate entry
  for (genvar g = 0; g < NUM_RELAYS; g++) begin : g_relay
    logic        state, next_state;
    logic [15:0] timer, next_timer;
    logic        next_relay, next_led;

    always_comb begin
      logic signed [34:0] v, t1, t2, lo, hi, h;
      logic               in_a, in_b, want, tick;
      logic [15:0]        dly;
      v          = '0;
      t1         = '0;
      t2         = '0;
      lo         = '0;
      hi         = '0;
      h          = 35'(cfg[g].hysteresis_width);
      in_a       = 1'b0;
      in_b       = 1'b0;
      want       = state;
      tick       = cfg[g].tbase_sec ? tick_sec : tick_tenth;
      dly        = 16'h0;
      next_state = state;
      next_timer = 16'h0;
      case (cfg[g].src)
        RTC_SRC_RATE:  v = 35'(flow_rate);
        RTC_SRC_TOTAL: v = 35'(total_count);
        default:       v = 35'(batch_cnt);
      endcase
      if (cfg[g].src == RTC_SRC_PRE) begin
        t1 = 35'(cfg[0].sp1) - 35'(cfg[g].sp1);
        t2 = 35'(cfg[0].sp1) - 35'(cfg[g].sp2);
      end else begin
        t1 = 35'(cfg[g].sp1);
        t2 = 35'(cfg[g].sp2);
      end
      lo = (t1 < t2) ? t1 : t2;
      hi = (t1 < t2) ? t2 : t1;
      case (cfg[g].mode)
        RTC_MODE_ON, RTC_MODE_OFF: begin
          in_a = v > t1 + h;
          in_b = v < t1 - h;
          want = in_a ? (cfg[g].mode == RTC_MODE_ON)
                      : (cfg[g].mode != RTC_MODE_ON);
        end
        RTC_MODE_IN, RTC_MODE_OUT: begin
          in_a = (v > lo + h) && (v < hi - h);
          in_b = (v < lo - h) || (v > hi + h);
          want = in_a ? (cfg[g].mode == RTC_MODE_IN)
                      : (cfg[g].mode == RTC_MODE_OUT);
        end
        default: begin
          in_a = 1'b0;
          in_b = 1'b0;
        end
      endcase
      dly = want ? cfg[g].ton : cfg[g].toff;
      if ((in_a | in_b) && (want != state)) begin
        next_timer = timer + {15'h0, tick};
        if (timer >= dly) begin
          next_state = want;
          next_timer = 16'h0;
        end
      end
      // Out of zone or already matching leaves timer at zero
      if (cfg[g].src == RTC_SRC_BATCH) begin
        next_state = (g == 0) ? (bstate_n == RTC_B_RUN)
                              : (bstate_n == RTC_B_RUN);
        next_timer = 16'h0;
      end
      if (clear_ev && cfg[g].src inside {RTC_SRC_BATCH, RTC_SRC_PRE}
          && !prog_input_clear) begin
        next_state = 1'b0;
      end
      next_led = next_state;
      if (critical) begin
        case (cfg[g].fault)
          RTC_FA_ON:  next_led = 1'b1;
          RTC_FA_OFF: next_led = 1'b0;
          default:    next_led = led_out[g];
        endcase
      end
      next_relay = next_led & FITTED_MASK[g];
    end

    always_ff @(posedge core_clk) begin
      if (rst) begin
        state        <= 1'b0;
        timer        <= 16'h0;
        relay_out[g] <= 1'b0;
        led_out[g]   <= 1'b0;
      end else begin
        state        <= next_state;
        timer        <= next_timer;
        relay_out[g] <= next_relay;
        led_out[g]   <= next_led;
      end
    end
  end

endmodule

// *** logic/rtc_cfg.svh ***
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH
`define RTC_CLK_NS         100
`define RTC_TENTH_NS       100000000
`define RTC_ADDR_W         8
`define RTC_OFF_RESULT     8'h00
`define RTC_OFF_STATUS     8'h04
`define RTC_OFF_COUNT      8'h08
`define RTC_OFF_AUTO       8'h0C
`define RTC_OFF_RELAY0     8'h20
`define RTC_RELAY_STRIDE   8'h20
`define RTC_ROFF_CTRL      3'h0
`define RTC_ROFF_SP1       3'h1
`define RTC_ROFF_SP2       3'h2
`define RTC_ROFF_HYSTERESIS_WIDTH      3'h3
`define RTC_ROFF_DELAY     3'h4
`define RTC_CMD_CLEAR      32'h00000000
`define RTC_CMD_START      32'h00000001
`define RTC_CMD_STOP       32'h00000002
`define RTC_COUNT_CLR_KEY  32'h0000C1EA
`define RTC_SEC_TENTHS     8'h0A
`endif

// *** logic/rtc_pkg.sv ***
package rtc_pkg;
  typedef enum logic [1:0] {
    RTC_SRC_RATE  = 2'h0,
    RTC_SRC_TOTAL = 2'h1,
    RTC_SRC_BATCH = 2'h2,
    RTC_SRC_PRE   = 2'h3
  } rtc_src_e;
  typedef enum logic [2:0] {
    RTC_MODE_NONE = 3'h0,
    RTC_MODE_ON   = 3'h1,
    RTC_MODE_OFF  = 3'h2,
    RTC_MODE_IN   = 3'h3,
    RTC_MODE_OUT  = 3'h4
  } rtc_mode_e;
  typedef enum logic [1:0] {
    RTC_FA_HOLD = 2'h0,
    RTC_FA_ON   = 2'h1,
    RTC_FA_OFF  = 2'h2
  } rtc_fault_e;
  typedef enum logic [3:0] {
    RTC_B_IDLE  = 4'b0001,
    RTC_B_RUN   = 4'b0010,
    RTC_B_PAUSE = 4'b0100,
    RTC_B_DONE  = 4'b1000
  } rtc_bstate_e;
  typedef struct packed {
    rtc_src_e   src;
    rtc_mode_e  mode;
    rtc_fault_e fault;
    logic       tbase_sec;
    logic [31:0] sp1;
    logic [31:0] sp2;
    logic [31:0] hysteresis_width;
    logic [15:0] ton;
    logic [15:0] toff;
  } rtc_relay_cfg_s;
  typedef struct packed {
    logic        enable;
    logic        tbase_sec;
    logic [15:0] delay;
  } rtc_auto_cfg_s;
  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } rtc_avs_req_s;
endpackage

// *** sim/rtc_monitor.sv ***
`timescale 1ns/1ps
module rtc_monitor import rtc_pkg::*; #(
  parameter int          NUM_RELAYS   = 2,
  parameter logic [7:0]  FITTED_MASK  = 8'hFF,
  parameter int unsigned TENTH_CYCLES = 10
) (
  input wire logic                  core_clk,
  input wire logic                  rst,
  input wire rtc_avs_req_s          avs_req,
  input wire logic [31:0]           avs_readdata,
  input wire logic                  avs_waitrequest,
  input wire logic [31:0]           flow_rate,
  input wire logic [31:0]           total_count,
  input wire logic                  volume_pulse,
  input wire logic                  critical,
  input wire logic                  key_start_pause,
  input wire logic                  key_clear,
  input wire logic                  menu_clear,
  input wire logic                  prog_input_clear,
  input wire logic                  batch_count_clear,
  input wire logic [NUM_RELAYS-1:0] relay_out,
  input wire logic [NUM_RELAYS-1:0] led_out,
  input wire logic                  batch_overflow_flag
);
  logic [1:0] src0;
  logic [1:0] next_src0;
  logic [1:0] flt0;
  logic [1:0] next_flt0;
  logic       cfg_wr;
  // Primary relay setup is shadowed from taken bus writes; only ports are visible here
  assign cfg_wr = avs_req.write && avs_waitrequest && avs_req.address == 8'h20
                  && avs_req.byteenable[0];
  always_comb begin
    next_src0 = cfg_wr ? avs_req.writedata[1:0] : src0;
    next_flt0 = cfg_wr ? avs_req.writedata[6:5] : flt0;
  end
  always_ff @(posedge core_clk) begin
    src0 <= rst ? 2'h0 : next_src0;
    flt0 <= rst ? 2'h0 : next_flt0;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_wait_one;
    $fell(avs_waitrequest) |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("answer longer than one cycle");
  property p_take;
    (avs_req.read || avs_req.write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_take: assert property (p_take) else $error("request not answered next cycle");
  property p_unmapped;
    avs_req.read && avs_waitrequest && avs_req.address == 8'h10 |=> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_led_mirror;
    1'b1 |-> relay_out == (led_out & FITTED_MASK[NUM_RELAYS-1:0]);
  endproperty
  a_led_mirror: assert property (p_led_mirror) else $error("relay and led disagree");
  property p_fault_on;
    critical && flt0 == RTC_FA_ON ##1 critical |=> led_out[0];
  endproperty
  a_fault_on: assert property (p_fault_on) else $error("fault on not forced");
  property p_fault_off;
    critical && flt0 == RTC_FA_OFF ##1 critical |=> !led_out[0];
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("fault off not forced");
  property p_fault_hold;
    critical && flt0 == RTC_FA_HOLD ##1 critical[*2] |-> $stable(led_out[0]);
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault hold moved");
  property p_key_pause;
    key_start_pause && led_out[0] && src0 == RTC_SRC_BATCH && !critical && !key_clear
      && !menu_clear && !prog_input_clear |-> ##[1:2] !led_out[0];
  endproperty
  a_key_pause: assert property (p_key_pause) else $error("key did not pause");
  property p_host_off;
    avs_req.write && avs_waitrequest && avs_req.address == 8'h00 && src0 == RTC_SRC_BATCH
      && (avs_req.writedata == 32'h0 || avs_req.writedata == 32'h2) && !critical
      |-> ##[1:2] !led_out[0];
  endproperty
  a_host_off: assert property (p_host_off) else $error("host stop left relay on");
  property p_clear_off;
    (key_clear || menu_clear) && src0 == RTC_SRC_BATCH && !critical |-> ##[1:2] !led_out[0];
  endproperty
  a_clear_off: assert property (p_clear_off) else $error("clear left relay on");
  property p_ovf_rise;
    $rose(batch_overflow_flag) |-> $past(volume_pulse);
  endproperty
  a_ovf_rise: assert property (p_ovf_rise) else $error("overflow without a pulse");
endmodule
bind rtc_top rtc_monitor #(.NUM_RELAYS(NUM_RELAYS), .FITTED_MASK(FITTED_MASK),
  .TENTH_CYCLES(TENTH_CYCLES)) rtc_monitor_i (.core_clk(core_clk), .rst(rst),
  .avs_req(avs_req), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .flow_rate(flow_rate), .total_count(total_count), .volume_pulse(volume_pulse),
  .critical(critical), .key_start_pause(key_start_pause), .key_clear(key_clear),
  .menu_clear(menu_clear), .prog_input_clear(prog_input_clear),
  .batch_count_clear(batch_count_clear), .relay_out(relay_out), .led_out(led_out),
  .batch_overflow_flag(batch_overflow_flag));

// *** sim/rtc_valve_model.sv ***
`timescale 1ns/1ps
module rtc_valve_model (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic valve_open,
  input  wire logic slow,
  output logic      volume_pulse
);
  logic [3:0] div;
  logic [1:0] lag;
  // Valve needs a few cycles to close, so flow trails the relay drop
  always @(posedge core_clk) begin
    if (rst) begin
      div <= 4'h0;
      lag <= 2'h0;
      volume_pulse <= 1'b0;
    end else begin
      lag <= valve_open ? 2'h3 : (lag != 2'h0 ? lag - 2'h1 : 2'h0);
      div <= (div >= (slow ? 4'h4 : 4'h1)) ? 4'h0 : div + 4'h1;
      volume_pulse <= (valve_open || lag != 2'h0) && div == 4'h0;
    end
  end
endmodule

// *** sim/tb.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module tb import rtc_pkg::*; ;
  localparam logic [31:0] SP1 = 32'h96;
  localparam logic [31:0] SP2 = 32'h32;
  localparam logic [31:0] HY  = 32'hA;
  logic         core_clk, rst, critical, vpulse, slow, st, ovf, avs_waitrequest;
  rtc_avs_req_s req;
  logic [31:0]  avs_readdata, flow_rate, total_count, q, vcnt, v;
  logic [4:0]   pl;
  logic [1:0]   relay_out, led_out;
  int           seed, n_fail, checks, took;
  logic [31:0]  cv [8] = '{SP1+HY+1, SP1+HY, SP1, SP1-HY, SP1-HY-1, SP2+HY+1, SP2+HY, SP2-HY-1};
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  rtc_top #(.NUM_RELAYS(2), .FITTED_MASK(8'h01), .TENTH_CYCLES(10)) rtc_top_i (
    .core_clk(core_clk), .rst(rst), .avs_req(req), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .flow_rate(flow_rate), .total_count(total_count),
    .volume_pulse(vpulse), .critical(critical), .key_start_pause(pl[0]), .key_clear(pl[1]),
    .menu_clear(pl[2]), .prog_input_clear(pl[3]), .batch_count_clear(pl[4]),
    .relay_out(relay_out), .led_out(led_out), .batch_overflow_flag(ovf));
  rtc_valve_model rtc_valve_model_i (.core_clk(core_clk), .rst(rst),
    .valve_open(relay_out[0]), .slow(slow), .volume_pulse(vpulse));
  // Mirror of the batcher counter; clears win over a coincident pulse
  always @(posedge core_clk) begin
    if (rst || pl[3:1] != 3'h0 || (req.write && avs_waitrequest && req.address == 8'h00
        && req.writedata == 32'h0)) vcnt <= 32'h0;
    else if (vpulse) vcnt <= vcnt + 32'h1;
  end
  task automatic print_verdict;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    req.read <= !w;
    req.write <= w;
    req.address <= a;
    req.writedata <= d;
    req.byteenable <= 4'hF;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    if (n == 50) begin n_fail++; print_verdict(); end
  endtask
  task automatic cfg(input logic [7:0] b, input logic [31:0] c, input logic [31:0] s1,
                     input logic [31:0] s2, input logic [31:0] h, input logic [31:0] d);
    bus(1'b1, b, c);
    bus(1'b1, b + 8'h04, s1);
    bus(1'b1, b + 8'h08, s2);
    bus(1'b1, b + 8'h0C, h);
    bus(1'b1, b + 8'h10, d);
  endtask
  task automatic pulse(input logic [4:0] m);
    @(posedge core_clk);
    pl <= m;
    @(posedge core_clk);
    pl <= 5'h0;
  endtask
  task automatic wait_for(input int sel, input logic [31:0] val);
    for (took = 0; took < 300; took++) begin
      if (sel == 0 ? led_out[0] === val[0] : vcnt === val) break;
      @(posedge core_clk);
    end
    if (took == 300) begin n_fail++; print_verdict(); end
  endtask
  function automatic logic [31:0] ctl(rtc_src_e s, rtc_mode_e m, rtc_fault_e f);
    return {25'h0, f, m, s};
  endfunction
  function automatic logic exp_st(logic [31:0] x, rtc_mode_e md, logic prev);
    logic a, b;
    if (md == RTC_MODE_ON || md == RTC_MODE_OFF) begin
      a = x > SP1 + HY;
      b = x < SP1 - HY;
    end else begin
      a = x > SP2 + HY && x < SP1 - HY;
      b = x < SP2 - HY || x > SP1 + HY;
    end
    if (!a && !b) return prev;
    return a ^ (md == RTC_MODE_OFF || md == RTC_MODE_OUT);
  endfunction
  initial begin
    seed = 9266; n_fail = 0; checks = 0; rst = 1'b1; req = '0; flow_rate = 32'h0;
    total_count = 32'h0; critical = 1'b0; pl = 5'h0; slow = 1'b0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    `CHK(led_out, 2'h0)
    bus(1'b0, 8'h04, 32'h0); `CHK(q, 32'h1)
    bus(1'b0, 8'h08, 32'h0); `CHK(q, 32'h0)
    bus(1'b1, 8'h10, 32'hFFFFFFFF); bus(1'b0, 8'h10, 32'h0); `CHK(q, 32'h0)
    bus(1'b0, 8'h0C, 32'h0); `CHK(q, 32'h0)
    // Sources alternate so the ignored input carries noise
    for (int m = 1; m <= 4; m++) begin
      cfg(8'h40, ctl(rtc_src_e'(m % 2), rtc_mode_e'(m), RTC_FA_HOLD), SP1, SP2, HY, 32'h0);
      flow_rate <= 32'h0; total_count <= 32'h0;
      repeat (4) @(posedge core_clk);
      st = (m == 2 || m == 4);
      `CHK(led_out[1], st)
      for (int i = 0; i < 20; i++) begin
        v = i < 8 ? cv[i] : {$random(seed)} % 32'hDC;
        if (m % 2) begin total_count <= v; flow_rate <= $random(seed); end
        else begin flow_rate <= v; total_count <= $random(seed); end
        repeat (4) @(posedge core_clk);
        st = exp_st(v, rtc_mode_e'(m), st);
        `CHK(led_out[1], st)
        `CHK(relay_out[1], 1'b0)
      end
    end
    flow_rate <= 32'h0;
    cfg(8'h40, ctl(RTC_SRC_RATE, RTC_MODE_ON, RTC_FA_HOLD), SP1, 32'h0, HY, 32'h00030003);
    flow_rate <= 32'hC8; repeat (15) @(posedge core_clk); `CHK(led_out[1], 1'b0)
    repeat (45) @(posedge core_clk); `CHK(led_out[1], 1'b1)
    flow_rate <= 32'h0; repeat (15) @(posedge core_clk);
    flow_rate <= 32'hC8; repeat (10) @(posedge core_clk);
    flow_rate <= 32'h0; repeat (15) @(posedge core_clk); `CHK(led_out[1], 1'b1)
    repeat (45) @(posedge core_clk); `CHK(led_out[1], 1'b0)
    // One-second time base: two ticks needed, so nothing may switch in the first 60 cycles
    cfg(8'h40, ctl(RTC_SRC_RATE, RTC_MODE_ON, RTC_FA_HOLD) | 32'h80, SP1, 32'h0, HY, 32'h2);
    flow_rate <= 32'hC8; repeat (60) @(posedge core_clk); `CHK(led_out[1], 1'b0)
    repeat (300) @(posedge core_clk); `CHK(led_out[1], 1'b1)
    for (int f = 0; f < 3; f++) begin
      cfg(8'h20, ctl(RTC_SRC_RATE, RTC_MODE_ON, rtc_fault_e'(f)), 32'h64, 32'h0, 32'h0, 32'h0);
      cfg(8'h40, ctl(RTC_SRC_RATE, RTC_MODE_ON, rtc_fault_e'(f)), 32'h64, 32'h0, 32'h0, 32'h0);
      repeat (4) @(posedge core_clk); `CHK(led_out[1], 1'b1)
      critical <= 1'b1; repeat (4) @(posedge core_clk); `CHK(led_out[1], f != 2)
      critical <= 1'b0; repeat (4) @(posedge core_clk); `CHK(led_out[1], 1'b1)
    end
    cfg(8'h20, ctl(RTC_SRC_BATCH, RTC_MODE_NONE, RTC_FA_HOLD), 32'h6, 32'h0, 32'h0, 32'h0);
    cfg(8'h40, ctl(RTC_SRC_PRE, RTC_MODE_ON, RTC_FA_HOLD), 32'h2, 32'h0, 32'h0, 32'h0);
    slow <= 1'b1; repeat (10) @(posedge core_clk); pulse(5'h02);
    bus(1'b1, 8'h00, 32'h1); wait_for(0, 32'h1);
    bus(1'b0, 8'h08, 32'h0); `CHK(q, 32'h1)
    wait_for(1, 32'h2); pulse(5'h01); wait_for(0, 32'h0);
    repeat (10) @(posedge core_clk); bus(1'b0, 8'h00, 32'h0); `CHK(q, vcnt)
    bus(1'b0, 8'h04, 32'h0); `CHK(q[3:0], 4'h4)
    pulse(5'h01); wait_for(0, 32'h1);
    wait_for(1, 32'h4); repeat (2) @(posedge core_clk); `CHK(led_out[1], 1'b0)
    wait_for(0, 32'h0); `CHK(vcnt, 32'h6)
    `CHK(led_out[1], 1'b1)
    bus(1'b0, 8'h04, 32'h0); `CHK(q[3:0], 4'h8)
    bus(1'b0, 8'h08, 32'h0); `CHK(q, 32'h1)
    pulse(5'h08); wait_for(0, 32'h1); bus(1'b0, 8'h08, 32'h0); `CHK(q, 32'h2)
    bus(1'b1, 8'h00, 32'h2); wait_for(0, 32'h0);
    bus(1'b0, 8'h04, 32'h0); `CHK(q[3:0], 4'h4)
    bus(1'b1, 8'h00, 32'h1); wait_for(0, 32'h1);
    bus(1'b1, 8'h00, 32'h0); wait_for(0, 32'h0);
    bus(1'b0, 8'h04, 32'h0); `CHK(q[3:0], 4'h1)
    repeat (5) @(posedge core_clk); bus(1'b0, 8'h00, 32'h0); `CHK(q, vcnt)
    pulse(5'h01); wait_for(0, 32'h1); pulse(5'h04); wait_for(0, 32'h0);
    bus(1'b0, 8'h08, 32'h0); `CHK(q, 32'h3)
    pulse(5'h10); bus(1'b0, 8'h08, 32'h0); `CHK(q, 32'h0)
    bus(1'b1, 8'h0C, 32'h00020001); bus(1'b0, 8'h0C, 32'h0); `CHK(q, 32'h00020001)
    slow <= 1'b0; bus(1'b1, 8'h00, 32'h1);
    wait_for(0, 32'h1); wait_for(0, 32'h0); wait_for(0, 32'h1);
    `CHK(took >= 10 && took <= 40, 1'b1)
    bus(1'b0, 8'h08, 32'h0); `CHK(q, 32'h2)
    bus(1'b1, 8'h0C, 32'h0); `CHK(ovf, 1'b0)
    print_verdict();
  end
endmodule
